// >>> design/tdcrd_pkg.sv
/*
 Package for the result and status readout block: register indices,
 status field positions, opcodes, result formats and reset values.
 Assumes a single 10 MHz system clock and a byte-wise serial link.
*/
package tdcrd_pkg;
    // Register indices as printed
    localparam logic [2:0] ADR_RESULT_FIRST  = 3'h0;
    localparam logic [2:0] ADR_RESULT_FOURTH = 3'h3;
    localparam logic [2:0] ADR_STATUS        = 3'h4;
    localparam logic [2:0] ADR_ECHO          = 3'h5;
    // Opcodes
    localparam logic [4:0] OPC_READ_HI  = 5'h16;
    localparam logic [7:0] OPC_READ_ID  = 8'hb7;
    // Byte counts per access
    localparam logic [2:0] LEN_RESULT   = 3'h4;
    localparam logic [2:0] LEN_STATUS   = 3'h2;
    localparam logic [2:0] LEN_ECHO     = 3'h1;
    localparam logic [2:0] LEN_ID       = 3'h7;
    // Status field positions
    localparam int ST_PTR_LSB   = 0;
    localparam int ST_HIT1_LSB  = 3;
    localparam int ST_HIT2_LSB  = 6;
    localparam int ST_TDC_OVF   = 9;
    localparam int ST_PRE_OVF   = 10;
    localparam int ST_OPEN      = 11;
    localparam int ST_SHORT     = 12;
    localparam int ST_NVM_EQ    = 13;
    localparam int ST_NVM_MULTI = 14;
    localparam int ST_NVM_SINGLE = 15;
    // Result, reset and limit constants
    localparam logic [31:0] RES_OVERFLOW  = 32'hffffffff;
    localparam logic [31:0] RES_RESET     = 32'h00000000;
    localparam logic [15:0] STATUS_RESET  = 16'h0000;
    localparam logic [6:0]  FIRE_PHASE_MAX = 7'h0f;
    localparam logic [2:0]  PTR_LAST      = 3'h4;
    localparam logic [2:0]  HIT_MAX       = 3'h7;

    // Measurement kinds from the engine
    typedef enum logic [1:0] {
        TDCRD_MODE1_CAL   = 2'b00,
        TDCRD_MODE1_RAW   = 2'b01,
        TDCRD_MODE2       = 2'b11,
        TDCRD_TEMP        = 2'b10
    } tdcrd_kind_t;

    // Serial link phases, Gray along opcode then data
    typedef enum logic [1:0] {
        TDCRD_SP_OPC  = 2'b00,
        TDCRD_SP_DATA = 2'b01,
        TDCRD_SP_DONE = 2'b11
    } tdcrd_sp_t;

    // One result delivered by the measurement engine
    typedef struct packed {
        logic        valid;
        tdcrd_kind_t kind;
        logic        alu_ovf;
        logic [31:0] value;
    } tdcrd_result_t;

    // Event and flag inputs
    typedef struct packed {
        logic clear;
        logic hit1;
        logic hit2;
        logic tdc_ovf;
        logic pre_ovf;
        logic sens_open;
        logic sens_short;
        logic nvm_eq;
        logic nvm_multi;
        logic nvm_single;
    } tdcrd_evt_t;
endpackage : tdcrd_pkg

// >>> design/tdcrd_readout.sv
/*
 Read-side register bank of a two-channel time-to-digital converter:
 result registers, status, echo byte and identification bytes, shifted
 out over a mode-1 serial slave, plus fire pulse count decoding.
 Assumes the serial pins are asynchronous to mclk and the serial clock
 is at most about a tenth of mclk so every edge is seen after sampling.
*/
`timescale 1ns/1ps
module tdcrd_readout
    import tdcrd_pkg::*;
#(
    parameter int          ID_BYTES = 7,
    parameter logic [55:0] ID_VALUE = 56'h01234567_89abcd // Arbitrary
)
(
    input  wire logic          mclk,
    input  wire logic          rst_n,
    input  wire logic          sck,
    input  wire logic          sdi,
    input  wire logic          serial_select_n,
    output logic               sdo,
    output logic               interrupt_out_n,
    input  wire tdcrd_result_t res_in,
    input  wire tdcrd_evt_t    evt_in,
    input  wire logic          irq_set,
    input  wire logic [7:0]    echo_in,
    input  wire logic [3:0]    fire_low_bits,
    input  wire logic [2:0]    fire_pulse_count,
    output logic [6:0]         fire_total,
    output logic               fire_phase_enable
);

    // State of the block apart from the reset synchroniser and the filtered sck and select levels
    typedef struct packed {
        logic [2:0]  sck_s;
        logic [2:0]  ssn_s;
        logic [2:0]  sdi_s;
        logic [31:0] res0;
        logic [31:0] res1;
        logic [31:0] res2;
        logic [31:0] res3;
        logic [15:0] status;
        tdcrd_sp_t   phase;
        logic [7:0]  shift_in;
        logic [2:0]  bit_cnt;
        logic [55:0] shift_out;
        logic [2:0]  bytes_left;
        logic        first_edge;
        logic        sdo;
        logic        int_n;
        logic [6:0]  fire_total;
        logic        fire_ph_en;
    } tdcrd_state_t;

    tdcrd_state_t st_reg;
    tdcrd_state_t st_next;

    // Reset synchroniser kept apart: it runs on the raw reset
    logic [1:0] rst_sync_reg;
    logic       rst_int_n;
    assign rst_int_n = rst_sync_reg[1];

    // Filtered levels: second and third stages must agree
    logic sck_lvl;
    logic ssn_lvl;
    logic sck_rise;
    logic sck_fall;
    assign sck_rise = (st_reg.sck_s[2:1] == 2'b11) && !sck_lvl;
    assign sck_fall = (st_reg.sck_s[2:1] == 2'b00) && sck_lvl;

    logic sck_lvl_reg;
    logic ssn_lvl_reg;
    assign sck_lvl = sck_lvl_reg;
    assign ssn_lvl = ssn_lvl_reg;

    // Byte count for a read address
    function automatic logic [2:0] read_len(input logic [2:0] adr);
        if (adr <= ADR_RESULT_FOURTH)
            read_len = LEN_RESULT;
        else if (adr == ADR_STATUS)
            read_len = LEN_STATUS;
        else
            read_len = LEN_ECHO;
    endfunction : read_len

    // Format a result for storage by kind
    function automatic logic [31:0] fmt_res(input tdcrd_result_t r);
        case (r.kind)
            TDCRD_MODE1_CAL:
                fmt_res = r.alu_ovf ? RES_OVERFLOW : r.value;
            TDCRD_MODE1_RAW:
                fmt_res = {r.value[15:0], 16'h0000};
            TDCRD_MODE2, TDCRD_TEMP:
                fmt_res = r.value;
            default:
                fmt_res = r.value;
        endcase
    endfunction : fmt_res

    // Saturating three-bit counter
    function automatic logic [2:0] sat_inc(input logic [2:0] v);
        sat_inc = (v == HIT_MAX) ? v : v + 3'h1;
    endfunction : sat_inc

    // Next-state logic
    always_comb
    begin
        logic [2:0]  adr;
        logic [31:0] word;
        logic [7:0]  byte_in;
        adr     = 3'h0;
        word    = 32'h0;
        byte_in = 8'h0;
        st_next = st_reg;
        st_next.sck_s = {st_reg.sck_s[1:0], sck};
        st_next.ssn_s = {st_reg.ssn_s[1:0], serial_select_n};
        st_next.sdi_s = {st_reg.sdi_s[1:0], sdi};

        // Result storage at the pointer, pointer advances
        if (res_in.valid && st_reg.status[2:0] < PTR_LAST)
        begin
            case (st_reg.status[2:0])
                3'h0: st_next.res0 = fmt_res(res_in);
                3'h1: st_next.res1 = fmt_res(res_in);
                3'h2: st_next.res2 = fmt_res(res_in);
                default: st_next.res3 = fmt_res(res_in);
            endcase
            st_next.status[2:0] = st_reg.status[2:0] + 3'h1;
        end
        // Hit counters and sticky error flags; clear starts a new run
        if (evt_in.clear)
        begin
            st_next.status[12:0] = 13'h0000;
        end
        if (evt_in.hit1)
            st_next.status[5:3] = sat_inc(st_next.status[5:3]);
        if (evt_in.hit2)
            st_next.status[8:6] = sat_inc(st_next.status[8:6]);
        // Set wins over a clear in the same cycle
        if (evt_in.tdc_ovf)
            st_next.status[ST_TDC_OVF] = 1'b1;
        if (evt_in.pre_ovf)
            st_next.status[ST_PRE_OVF] = 1'b1;
        if (evt_in.sens_open)
            st_next.status[ST_OPEN] = 1'b1;
        if (evt_in.sens_short)
            st_next.status[ST_SHORT] = 1'b1;
        st_next.status[ST_NVM_EQ]     = evt_in.nvm_eq;
        st_next.status[ST_NVM_MULTI]  = evt_in.nvm_multi;
        st_next.status[ST_NVM_SINGLE] = evt_in.nvm_single;

        // Fire pulse count: three high bits joined with four low bits
        st_next.fire_total = {fire_pulse_count, fire_low_bits};
        st_next.fire_ph_en = ({fire_pulse_count, fire_low_bits}
                              <= FIRE_PHASE_MAX);

        // Interrupt asserted by engine, released by first sck rise
        if (irq_set)
            st_next.int_n = 1'b0;
        if (sck_rise && st_reg.first_edge && !ssn_lvl)
        begin
            st_next.int_n = 1'b1;
            st_next.first_edge = 1'b0;
        end

        // Serial slave: select high resets the interface
        if (ssn_lvl)
        begin
            st_next.phase      = TDCRD_SP_OPC;
            st_next.bit_cnt    = 3'h0;
            st_next.bytes_left = 3'h0;
            st_next.first_edge = 1'b1;
            st_next.sdo        = 1'b0;          // No stale bit after a frame
        end
        else if (sck_rise && st_reg.phase == TDCRD_SP_DATA)
        begin
            // Launch on the rise so the bit is settled when the host takes it
            st_next.sdo = st_reg.shift_out[55];
            st_next.shift_out = {st_reg.shift_out[54:0], 1'b0};
        end
        else if (sck_fall)
        begin
            // Sample input on the falling edge
            byte_in = {st_reg.shift_in[6:0], st_reg.sdi_s[2]};
            st_next.shift_in = byte_in;
            st_next.bit_cnt  = st_reg.bit_cnt + 3'h1;
            if (st_reg.bit_cnt == 3'h7)
            begin
                if (st_reg.phase == TDCRD_SP_OPC)
                begin
                    adr = byte_in[2:0];
                    case (adr)
                        3'h0: word = st_reg.res0;
                        3'h1: word = st_reg.res1;
                        3'h2: word = st_reg.res2;
                        3'h3: word = st_reg.res3;
                        3'h4: word = {st_reg.status, 16'h0000};
                        default: word = {echo_in, 24'h000000};
                    endcase
                    if (byte_in == OPC_READ_ID)
                    begin
                        st_next.shift_out  = ID_VALUE;
                        st_next.bytes_left = LEN_ID;
                        st_next.phase      = TDCRD_SP_DATA;
                    end
                    else if (byte_in[7:3] == OPC_READ_HI)
                    begin
                        st_next.shift_out  = {word, 24'h000000};
                        st_next.bytes_left = read_len(adr);
                        st_next.phase      = TDCRD_SP_DATA;
                    end
                    else
                        st_next.phase = TDCRD_SP_DONE;
                end
                else if (st_reg.phase == TDCRD_SP_DATA)
                begin
                    st_next.bytes_left = st_reg.bytes_left - 3'h1;
                    if (st_reg.bytes_left == 3'h1)
                        st_next.phase = TDCRD_SP_DONE;
                end
            end
        end
    end

    // Reset synchroniser runs on the raw reset
    always_ff @(posedge mclk or negedge rst_n)
    begin
        if (!rst_n)
            rst_sync_reg <= 2'b00;
        else
            rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end

    // Remaining state on the synchronised reset
    always_ff @(posedge mclk or negedge rst_int_n)
    begin
        if (!rst_int_n)
        begin
            st_reg.sck_s      <= 3'b000;
            st_reg.ssn_s      <= 3'b111;
            st_reg.sdi_s      <= 3'b000;
            st_reg.res0       <= RES_RESET;
            st_reg.res1       <= RES_RESET;
            st_reg.res2       <= RES_RESET;
            st_reg.res3       <= RES_RESET;
            st_reg.status     <= STATUS_RESET;
            st_reg.phase      <= TDCRD_SP_OPC;
            st_reg.shift_in   <= 8'h00;
            st_reg.bit_cnt    <= 3'h0;
            st_reg.shift_out  <= 56'h0;
            st_reg.bytes_left <= 3'h0;
            st_reg.first_edge <= 1'b1;
            st_reg.sdo        <= 1'b0;
            st_reg.int_n      <= 1'b1;
            st_reg.fire_total <= 7'h00;
            st_reg.fire_ph_en <= 1'b1;
            sck_lvl_reg       <= 1'b0;
            ssn_lvl_reg       <= 1'b1;
        end
        else
        begin
            st_reg.sck_s      <= st_next.sck_s;
            st_reg.ssn_s      <= st_next.ssn_s;
            st_reg.sdi_s      <= st_next.sdi_s;
            st_reg.res0       <= st_next.res0;
            st_reg.res1       <= st_next.res1;
            st_reg.res2       <= st_next.res2;
            st_reg.res3       <= st_next.res3;
            st_reg.status     <= st_next.status;
            st_reg.phase      <= st_next.phase;
            st_reg.shift_in   <= st_next.shift_in;
            st_reg.bit_cnt    <= st_next.bit_cnt;
            st_reg.shift_out  <= st_next.shift_out;
            st_reg.bytes_left <= st_next.bytes_left;
            st_reg.first_edge <= st_next.first_edge;
            st_reg.sdo        <= st_next.sdo;
            st_reg.int_n      <= st_next.int_n;
            st_reg.fire_total <= st_next.fire_total;
            st_reg.fire_ph_en <= st_next.fire_ph_en;
            // Level changes only when stages two and three agree
            if (st_reg.sck_s[2] == st_reg.sck_s[1])
                sck_lvl_reg <= st_reg.sck_s[2];
            if (st_reg.ssn_s[2] == st_reg.ssn_s[1])
                ssn_lvl_reg <= st_reg.ssn_s[2];
        end
    end

    assign sdo               = st_reg.sdo;
    assign interrupt_out_n   = st_reg.int_n;
    assign fire_total        = st_reg.fire_total;
    assign fire_phase_enable = st_reg.fire_ph_en;

    // Overflowed calibrated mode-one result lands as all ones
    property ovf_store_p;
        @(posedge mclk) disable iff (!rst_int_n)
        (res_in.valid && res_in.kind == TDCRD_MODE1_CAL && res_in.alu_ovf
         && st_reg.status[2:0] == 3'h0) |=> (st_reg.res0 == RES_OVERFLOW);
    endproperty
    alu_overflow_a: assert property (ovf_store_p)
        else $error("overflow result not all ones");

    raw_low_zero_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        (res_in.valid && res_in.kind == TDCRD_MODE1_RAW
         && st_reg.status[2:0] == 3'h0) |=> (st_reg.res0[15:0] == 16'h0))
        else $error("raw result low half not zero");

    pointer_step_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        (res_in.valid && !evt_in.clear && st_reg.status[2:0] < PTR_LAST)
        |=> (st_reg.status[2:0] == $past(st_reg.status[2:0]) + 3'h1))
        else $error("result pointer did not advance");

    tdc_ovf_flag_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        evt_in.tdc_ovf |=> st_reg.status[ST_TDC_OVF])
        else $error("tdc overflow flag not set");

    pre_ovf_flag_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        evt_in.pre_ovf |=> st_reg.status[ST_PRE_OVF])
        else $error("precounter overflow flag not set");

    sensor_flags_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        (evt_in.sens_open && evt_in.sens_short)
        |=> (st_reg.status[ST_OPEN] && st_reg.status[ST_SHORT]))
        else $error("sensor flags not set");

    nvm_flags_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        ##1 (st_reg.status[15:13] == $past({evt_in.nvm_single,
            evt_in.nvm_multi, evt_in.nvm_eq})))
        else $error("nvm flags do not follow inputs");

    phase_gate_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        ({fire_pulse_count, fire_low_bits} > FIRE_PHASE_MAX)
        |=> !fire_phase_enable)
        else $error("phase pattern active above fifteen");

    sequence sel_low_rise_s;
        !ssn_lvl && sck_rise && st_reg.first_edge;
    endsequence
    int_release_a: assert property (
        @(posedge mclk) disable iff (!rst_int_n)
        sel_low_rise_s |=> interrupt_out_n)
        else $error("interrupt not released on first rise");

endmodule : tdcrd_readout

// >>> verification/tdcrd_host.sv
/*
 Host model: a serial master in clock polarity zero, phase one.
 Assumes the half period is well above ten system clocks so the
 device sees every edge; the bench calls xfer hierarchically.
*/
`timescale 1ns/1ps
module tdcrd_host
#(
    parameter int HALF_NS = 2000,
    parameter int SKEW_NS = 7     // Keeps link edges off the mclk edges
)
(
    output logic      sck,
    output logic      sdi,
    output logic      serial_select_n,
    input  wire logic sdo
);
    // Link idles with clock low and the device deselected
    initial
    begin
        sck             = 1'b0;
        sdi             = 1'b0;
        serial_select_n = 1'b1;
    end

    // One framed transfer: opcode byte, then nbytes read back MSB first
    task automatic xfer(input logic [7:0] opc, input int nbytes,
                        output logic [63:0] rd);
        int i;
        rd = '0;
        #SKEW_NS;
        serial_select_n = 1'b0;
        #HALF_NS;
        for (i = 0; i < 8 + 8 * nbytes; i++)
        begin
            sck = 1'b1;
            // Data changes on the rising edge, read side toggles as junk
            sdi = (i < 8) ? opc[7 - i] : ~sdi;
            #HALF_NS;
            if (i >= 8)
                rd = {rd[62:0], sdo}; // taken at the falling edge
            sck = 1'b0;
            #HALF_NS;
        end
        // Deselect ends the frame; sdi shows no stale level afterwards
        serial_select_n = 1'b1;
        sdi = ~sdi;
        #HALF_NS;
    endtask : xfer
endmodule : tdcrd_host

// >>> verification/tdcrd_readout_bench.sv
/*
 Self-checking bench for the readout block with a host model.
 Assumes the host model is driven hierarchically and mclk is 10 MHz.
*/
`timescale 1ns/1ps
module tdcrd_readout_bench
    import tdcrd_pkg::*;
;
    localparam int          STEP   = 10;
    localparam int          HALF   = 2000;
    localparam logic [55:0] ID_VAL = 56'h5a3c96e10f72b4; // Arbitrary

    typedef struct packed {
        tdcrd_kind_t kind;
        logic        ovf;
        logic [31:0] val;
        logic [31:0] exp;
    } tdcrd_row_t;

    logic          mclk, rst_n, sck, sdi, serial_select_n, sdo;
    logic          interrupt_out_n, irq_set, fire_phase_enable;
    tdcrd_result_t res_in;
    tdcrd_evt_t    evt_in, ev, nvm;
    logic [7:0]    echo_in;
    logic [3:0]    fire_low_bits;
    logic [2:0]    fire_pulse_count;
    logic [6:0]    fire_total, fexp;
    logic [63:0]   rd;
    int            errors, n_checks, i;
    tdcrd_row_t    rows [6] = '{
        '{TDCRD_MODE1_CAL, 1'b0, 32'h12345678, 32'h12345678},
        '{TDCRD_MODE1_CAL, 1'b1, 32'h00001111, 32'hffffffff},
        '{TDCRD_MODE1_RAW, 1'b0, 32'hdead8001, 32'h80010000},
        '{TDCRD_MODE1_CAL, 1'b0, 32'hfffe8000, 32'hfffe8000},
        '{TDCRD_MODE2,     1'b0, 32'h00038000, 32'h00038000},
        '{TDCRD_TEMP,      1'b0, 32'h00014000, 32'h00014000}};

    tdcrd_readout #(.ID_VALUE(ID_VAL)) tdcrd_readout_inst (
        .mclk(mclk), .rst_n(rst_n), .sck(sck), .sdi(sdi),
        .serial_select_n(serial_select_n), .sdo(sdo),
        .interrupt_out_n(interrupt_out_n), .res_in(res_in),
        .evt_in(evt_in), .irq_set(irq_set), .echo_in(echo_in),
        .fire_low_bits(fire_low_bits),
        .fire_pulse_count(fire_pulse_count), .fire_total(fire_total),
        .fire_phase_enable(fire_phase_enable));

    tdcrd_host #(.HALF_NS(HALF)) tdcrd_host_inst (
        .sck(sck), .sdi(sdi), .serial_select_n(serial_select_n),
        .sdo(sdo));

    // 100 ns system clock
    always #50 mclk = ~mclk;

    task automatic check(input logic [63:0] seen, input logic [63:0] exp);
        n_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("wrong value at %0t: saw %h expected %h",
                     $time, seen, exp);
        end
    endtask : check

    task automatic report_and_stop;
        $display("checks %0d errors %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : report_and_stop

    // One-cycle event pulse; nvm levels stay applied throughout
    task automatic pulse(input tdcrd_evt_t e);
        @(posedge mclk);
        #STEP evt_in = e | nvm;
        @(posedge mclk);
        #STEP evt_in = nvm;
    endtask : pulse

    task automatic put(input tdcrd_kind_t k, input logic o,
                       input logic [31:0] v);
        @(posedge mclk);
        #STEP res_in = '{1'b1, k, o, v};
        @(posedge mclk);
        #STEP res_in.valid = 1'b0;
    endtask : put

    task automatic rd_reg(input logic [2:0] adr, input int n);
        tdcrd_host_inst.xfer({OPC_READ_HI, adr}, n, rd);
    endtask : rd_reg

    task automatic clear_all;
        ev = '0;
        ev.clear = 1'b1;
        pulse(ev);
    endtask : clear_all

    // Watchdog sized at about twice the expected run
    initial
    begin
        #4_000_000;
        errors++;
        report_and_stop();
    end

    initial
    begin
        mclk = 1'b0; rst_n = 1'b0; irq_set = 1'b0; res_in = '0;
        evt_in = '0; nvm = '0; echo_in = 8'ha5;
        fire_low_bits = 4'h0; fire_pulse_count = 3'h0;
        errors = 0; n_checks = 0;
        repeat (5) @(posedge mclk);
        #STEP check({62'h0, sdo, interrupt_out_n}, 64'h1);
        check({56'h0, fire_phase_enable, fire_total}, 64'h80);
        repeat (5) @(posedge mclk);
        #STEP rst_n = 1'b1;
        repeat (8) @(posedge mclk);
        rd_reg(ADR_STATUS, 2);
        check(rd, 64'h0);
        // Ordinary result formats, one row each
        for (i = 0; i < 6; i++)
        begin
            clear_all();
            put(rows[i].kind, rows[i].ovf, rows[i].val);
            rd_reg(ADR_RESULT_FIRST, 4);
            check(rd, {32'h0, rows[i].exp});
        end
        // Fill every result slot; a fifth result must be dropped
        clear_all();
        for (i = 1; i <= 5; i++)
            put(TDCRD_MODE2, 1'b0, {16'h0, 8'(i), 8'h00});
        rd_reg(ADR_RESULT_FOURTH, 4);
        check(rd, 64'h400);
        // Status fields, second hit counter pushed past saturation
        ev = '0; ev.hit1 = 1'b1;
        repeat (3) pulse(ev);
        ev = '0; ev.hit2 = 1'b1;
        repeat (9) pulse(ev);
        ev = '0; ev.tdc_ovf = 1'b1; ev.pre_ovf = 1'b1;
        ev.sens_open = 1'b1; ev.sens_short = 1'b1;
        nvm.nvm_eq = 1'b1; nvm.nvm_multi = 1'b1;
        pulse(ev);
        rd_reg(ADR_STATUS, 2);
        check(rd, {48'h0, 7'b0111111, HIT_MAX, 3'h3, PTR_LAST});
        nvm = '0; nvm.nvm_single = 1'b1;
        pulse('0);
        rd_reg(ADR_STATUS, 2);
        check(rd, {48'h0, 7'b1001111, HIT_MAX, 3'h3, PTR_LAST});
        // Identification bytes, first byte leading
        tdcrd_host_inst.xfer(OPC_READ_ID, 7, rd);
        check(rd, {8'h0, ID_VAL});
        // Abort after two bytes, then a fresh echo read
        rd_reg(ADR_RESULT_FIRST, 2);
        check(rd, 64'h0);
        rd_reg(ADR_ECHO, 1);
        check(rd, 64'ha5);
        tdcrd_host_inst.xfer(8'h80, 1, rd);
        check(rd, 64'h0);
        // Interrupt holds through select and drops at the first rise
        @(posedge mclk);
        #STEP irq_set = 1'b1;
        @(posedge mclk);
        #STEP irq_set = 1'b0;
        repeat (2) @(posedge mclk);
        fork
            rd_reg(ADR_ECHO, 1);
            begin
                #(HALF - 100) check({63'h0, interrupt_out_n}, 64'h0);
                #(HALF) check({63'h0, interrupt_out_n}, 64'h1);
            end
        join
        // Fire count decode across every top field and the 15/16 edge
        for (i = 0; i < 9; i++)
        begin
            fexp = (i == 8) ? 7'h10 : {i[2:0], 4'hf};
            @(posedge mclk);
            #STEP fire_pulse_count = fexp[6:4];
            fire_low_bits = fexp[3:0];
            repeat (3) @(posedge mclk);
            check({57'h0, fire_total}, {57'h0, fexp});
            check({63'h0, fire_phase_enable}, {63'h0, fexp <= 7'h0f});
        end
        report_and_stop();
    end
endmodule : tdcrd_readout_bench
